// file: rtl/ctec_top.sv
// Charge-time edge control: control register, edge status flags, delay, trigger, discharge.
// Assumes a 16-bit register port, timer pulses on CLK, asynchronous edge pins.
// Function
// R1 - Delay-generation bit set produces edge delays; clear disables them.
// R2 - Hardware edge select set lets timers and edge pins set edge flags.
// R3 - Hardware edge select clear: only software writes set the edge flags.
// R4 - Edge order enabled: edge 2 accepted only after edge 1 occurred. The code also accepts edge 2 in the same cycle as edge 1.
// R5 - Discharge bit set grounds the current source output; clear leaves it.
// R6 - Conversion trigger bit set issues start-of-conversion to the ADC.
// R7 - Software discharges the sample capacitor before measuring.
// R8 - ADC stays sampling while discharge is active.
// R9 - Enable clear or idle with idle-stop halts all activity.
`timescale 1ns/100ps
module ctec_top #(
  parameter int DELAY_COUNT = ctec_pkg::DELAY_CYCLES
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  input wire logic CPU_IDLE,
  input wire logic TIMER_EDGE1,
  input wire logic TIMER_EDGE2,
  input wire logic [1:0] EDGE_PIN,
  output logic SOURCE_ON,
  output logic DELAY_DONE,
  output logic ADC_SOC,
  output logic SOURCE_GROUND
);
  typedef enum logic [1:0] {IDLE, WAIT1, WAIT2, DELAY} ctec_state_type;
  ctec_sync_if sync_bus ();
  logic [15:0] ctrl_reg, ctrl_next, rdata_reg, rdata_next;
  logic [1:0] stat_reg, stat_next;
  logic [15:0] cnt_reg, cnt_next;
  ctec_state_type st_reg, st_next;
  logic src_reg, src_next, done_reg, done_next, soc_reg, soc_next, gnd_reg, gnd_next;
  logic active, hw, set1, set2, wr_ctrl, wr_stat;

  ctec_edge_sync u_sync (
    .clk(CLK),
    .arst_n(ARST_N),
    .raw_in(EDGE_PIN),
    .sync(sync_bus.src)
  );

  always_comb begin
    // R9 enable and idle-stop
    active = ctrl_reg[ctec_pkg::UNIT_EN_BIT] &
             ~(ctrl_reg[ctec_pkg::IDLE_STOP_BIT] & CPU_IDLE);
    hw = ctrl_reg[ctec_pkg::HW_EDGE_BIT];
    wr_ctrl = WR && (ADDR == ctec_pkg::CTRL_ONE_ADDR);
    wr_stat = WR && (ADDR == ctec_pkg::EDGE_STAT_ADDR);
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_next = WDATA & ctec_pkg::CTRL_ONE_MASK;
    end
    // R2 hardware sources; R3 software writes only when clear
    set1 = active & (hw ? (TIMER_EDGE1 | sync_bus.edge1_rise)
                        : (wr_stat & WDATA[ctec_pkg::EDGE1_STAT_BIT]));
    set2 = active & (hw ? (TIMER_EDGE2 | sync_bus.edge2_rise)
                        : (wr_stat & WDATA[ctec_pkg::EDGE2_STAT_BIT]));
    // R4 edge order gating
    if (ctrl_reg[ctec_pkg::EDGE_ORDER_BIT] && !(stat_reg[0] || set1)) begin
      set2 = 1'b0;
    end
    stat_next = stat_reg;
    if (wr_stat) begin
      stat_next = WDATA[1:0] & stat_reg;
    end
    // Set wins over a clearing write in the same cycle
    if (set1) begin
      stat_next[0] = 1'b1;
    end
    if (set2) begin
      stat_next[1] = 1'b1;
    end
    rdata_next = 16'h0000;
    if (RD && ADDR == ctec_pkg::CTRL_ONE_ADDR) begin
      rdata_next = ctrl_reg;
    end else if (RD && ADDR == ctec_pkg::EDGE_STAT_ADDR) begin
      rdata_next = {14'h0000, stat_reg};
    end
  end

  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    src_next = 1'b0;
    done_next = 1'b0;
    soc_next = 1'b0;
    // R5 discharge grounding
    gnd_next = active & ctrl_reg[ctec_pkg::DISCHARGE_BIT];
    if (!active) begin
      st_next = IDLE;
    end else begin
      unique case (st_reg)
        IDLE: begin
          if (stat_next[0] && !stat_next[1]) begin
            st_next = WAIT2;
          end else begin
            st_next = WAIT1;
          end
        end
        WAIT1: begin
          if (stat_next[0] && !stat_next[1]) begin
            st_next = WAIT2;
          end
        end
        WAIT2: begin
          src_next = 1'b1;
          if (stat_next[1]) begin
            // R1 delay generation
            if (ctrl_reg[ctec_pkg::DELAY_GEN_BIT]) begin
              st_next = DELAY;
              cnt_next = 16'(DELAY_COUNT - 1);
            end else begin
              st_next = WAIT1;
              done_next = 1'b1;
              // R6 conversion trigger
              soc_next = ctrl_reg[ctec_pkg::CONV_TRIG_BIT];
            end
          end else if (!stat_next[0]) begin
            st_next = WAIT1;
          end
        end
        DELAY: begin
          if (cnt_reg == 16'h0000) begin
            st_next = WAIT1;
            done_next = 1'b1;
            // R6 conversion trigger
            soc_next = ctrl_reg[ctec_pkg::CONV_TRIG_BIT];
          end else begin
            cnt_next = cnt_reg - 16'h0001;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl_reg <= ctec_pkg::CTRL_ONE_RESET;
      stat_reg <= ctec_pkg::EDGE_STAT_RESET;
      rdata_reg <= 16'h0000;
      cnt_reg <= 16'h0000;
      st_reg <= IDLE;
      src_reg <= 1'b0;
      done_reg <= 1'b0;
      soc_reg <= 1'b0;
      gnd_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      stat_reg <= stat_next;
      rdata_reg <= rdata_next;
      cnt_reg <= cnt_next;
      st_reg <= st_next;
      src_reg <= src_next;
      done_reg <= done_next;
      soc_reg <= soc_next;
      gnd_reg <= gnd_next;
    end
  end

  assign RDATA = rdata_reg;
  assign SOURCE_ON = src_reg;
  assign DELAY_DONE = done_reg;
  assign ADC_SOC = soc_reg;
  assign SOURCE_GROUND = gnd_reg;

  // R4 ordering check
  a_edge_order_gate: assert property (@(posedge CLK) disable iff (!ARST_N) // R4
    (ctrl_reg[ctec_pkg::EDGE_ORDER_BIT] && !stat_reg[0] && !stat_reg[1]) |=>
      (stat_reg[0] || !stat_reg[1]))
    else $error("edge 2 accepted before edge 1");
  // R3 software only
  a_sw_edge_only: assert property (@(posedge CLK) disable iff (!ARST_N) // R3
    (!hw && !wr_stat) |=> (stat_reg & ~$past(stat_reg)) == 2'h0)
    else $error("edge flag set without software write");
  // R2 hardware source
  a_hw_edge_set: assert property (@(posedge CLK) disable iff (!ARST_N) // R2
    (active && hw && TIMER_EDGE1) |=> stat_reg[0])
    else $error("timer edge 1 not recorded");
  // R5 ground follows bit
  a_ground_follow: assert property (@(posedge CLK) disable iff (!ARST_N) // R5
    SOURCE_GROUND == $past(active & ctrl_reg[ctec_pkg::DISCHARGE_BIT]))
    else $error("ground output wrong");
  // R6 trigger gated
  a_soc_gated: assert property (@(posedge CLK) disable iff (!ARST_N) // R6
    ADC_SOC |-> DELAY_DONE && $past(ctrl_reg[ctec_pkg::CONV_TRIG_BIT]))
    else $error("conversion trigger without enable");
  // R1 delay length
  a_delay_length: assert property (@(posedge CLK) disable iff (!ARST_N) // R1
    (st_reg == WAIT2 && st_next == DELAY) |=>
      (cnt_reg == 16'(DELAY_COUNT - 1) && !DELAY_DONE))
    else $error("delay started with wrong count");
  // R1 delay countdown
  a_delay_count: assert property (@(posedge CLK) disable iff (!ARST_N) // R1
    (st_reg == DELAY && active && cnt_reg != 16'h0000) |=>
      (st_reg == DELAY && cnt_reg == $past(cnt_reg) - 16'h0001 && !DELAY_DONE))
    else $error("delay ended early");
  // R9 halted when disabled
  a_disabled_quiet: assert property (@(posedge CLK) disable iff (!ARST_N) // R9
    !active |=> !SOURCE_ON && !ADC_SOC && !SOURCE_GROUND && !DELAY_DONE)
    else $error("activity while disabled");
  // R9 idle stop
  a_idle_halt: assert property (@(posedge CLK) disable iff (!ARST_N) // R9
    (ctrl_reg[ctec_pkg::IDLE_STOP_BIT] && CPU_IDLE) |=> st_reg == IDLE)
    else $error("running during idle stop");
  c_hw_measure: cover property (@(posedge CLK) disable iff (!ARST_N) hw && DELAY_DONE);
  c_sw_measure: cover property (@(posedge CLK) disable iff (!ARST_N) !hw && DELAY_DONE);
  c_soc: cover property (@(posedge CLK) disable iff (!ARST_N) ADC_SOC);
  c_ground: cover property (@(posedge CLK) disable iff (!ARST_N) SOURCE_GROUND);
endmodule // ctec_top

// file: inc/ctec_pkg.sv
// Package for the charge-time edge control block: register map, field positions, timing.
// Assumes a 16-bit register port with one-cycle read latency.
package ctec_pkg;
  localparam logic [3:0] CTRL_ONE_ADDR = 4'h0;
  localparam logic [3:0] EDGE_STAT_ADDR = 4'h1;
  localparam int UNIT_EN_BIT = 15;
  localparam int IDLE_STOP_BIT = 13;
  localparam int DELAY_GEN_BIT = 12;
  localparam int HW_EDGE_BIT = 11;
  localparam int EDGE_ORDER_BIT = 10;
  localparam int DISCHARGE_BIT = 9;
  localparam int CONV_TRIG_BIT = 8;
  localparam int EDGE1_STAT_BIT = 0;
  localparam int EDGE2_STAT_BIT = 1;
  localparam logic [15:0] CTRL_ONE_MASK = 16'hbf00;
  localparam logic [15:0] CTRL_ONE_RESET = 16'h0000;
  localparam logic [1:0] EDGE_STAT_RESET = 2'h0;
  localparam int DELAY_NS = 100;
  localparam int CLK_NS = 10;
  localparam int DELAY_CYCLES = (DELAY_NS + CLK_NS - 1) / CLK_NS;
endpackage

// file: inc/ctec_sync_if.sv
// Interface carrying the synchronised edge sources from the input stage to the top.
// Assumes one clock domain.
`timescale 1ns/100ps
interface ctec_sync_if;
  logic edge1_rise;
  logic edge2_rise;
  modport src (output edge1_rise, output edge2_rise);
  modport dst (input edge1_rise, input edge2_rise);
endinterface

// file: rtl/ctec_edge_sync.sv
// Three-stage synchroniser and rising-edge detector for two external edge sources.
// Assumes asynchronous inputs and a single clock.
`timescale 1ns/100ps
module ctec_edge_sync (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [1:0] raw_in,
  ctec_sync_if.src sync
);
  logic [1:0] s1_reg, s2_reg, s3_reg, prev_reg;
  logic [1:0] s1_next, s2_next, s3_next, prev_next;
  logic [1:0] level;
  // Only stages two and three are compared; stage one feeds stage two alone
  always_comb begin
    s1_next = raw_in;
    s2_next = s1_reg;
    s3_next = s2_reg;
    level = prev_reg;
    for (int i = 0; i < 2; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        level[i] = s3_reg[i];
      end
    end
    prev_next = level;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_reg <= 2'h0;
      s2_reg <= 2'h0;
      s3_reg <= 2'h0;
      prev_reg <= 2'h0;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
      prev_reg <= prev_next;
    end
  end
  assign sync.edge1_rise = level[0] & ~prev_reg[0];
  assign sync.edge2_rise = level[1] & ~prev_reg[1];
endmodule // ctec_edge_sync

// file: verification/ctec_far_model.sv
// Far-side model: timer pulses, external edge pins and an ADC that samples.
// Assumes the bench calls its tasks and CLK is the block clock.
`timescale 1ns/100ps
module ctec_far_model (
  input wire logic CLK,
  input wire logic ADC_SOC,
  input wire logic SOURCE_GROUND,
  output logic TIMER_EDGE1,
  output logic TIMER_EDGE2,
  output logic [1:0] EDGE_PIN,
  output logic SAMPLING
);
  int soc_seen = 0;
  initial begin
    TIMER_EDGE1 = 1'b0;
    TIMER_EDGE2 = 1'b0;
    EDGE_PIN = 2'h0;
  end
  assign SAMPLING = SOURCE_GROUND;
  always @(posedge CLK) begin
    if (ADC_SOC === 1'b1) soc_seen <= soc_seen + 1;
  end
  task automatic tmr(input int i);
    @(posedge CLK);
    if (i == 1) TIMER_EDGE1 <= 1'b1;
    else TIMER_EDGE2 <= 1'b1;
    @(posedge CLK);
    TIMER_EDGE1 <= 1'b0;
    TIMER_EDGE2 <= 1'b0;
  endtask
  // Pins are asynchronous, so change them away from the edge
  task automatic pin(input logic [1:0] v);
    #3 EDGE_PIN = v;
  endtask
endmodule // ctec_far_model

// file: verification/tb_ctec_top.sv
// Testbench for the charge-time edge control block.
// Assumes a 100 MHz clock and the far-side model beside the design.
`timescale 1ns/100ps
module tb_ctec_top;
  logic CLK = 1'b0, ARST_N = 1'b0, WR = 1'b0, RD = 1'b0, CPU_IDLE = 1'b0;
  logic [3:0] ADDR = 4'h0;
  logic [15:0] WDATA = 16'h0000, RDATA;
  logic t1, t2, son, done, soc, gnd, smp;
  logic [1:0] pins;
  int n_mismatch = 0, checks_done = 0, n;
  // Short delay keeps the run brief
  localparam int DLY = 2;
  // Write data, readback, expected ground level
  logic [15:0] rows [5][3] = '{'{16'hffff, 16'hbf00, 16'h1}, '{16'h0200, 16'h0200, 16'h0},
    '{16'h8200, 16'h8200, 16'h1}, '{16'h4000, 16'h0000, 16'h0}, '{16'h0000, 16'h0000, 16'h0}};
  initial forever #5 CLK = ~CLK;
  ctec_top #(.DELAY_COUNT(DLY)) uut (.CLK(CLK), .ARST_N(ARST_N), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .CPU_IDLE(CPU_IDLE), .TIMER_EDGE1(t1), .TIMER_EDGE2(t2),
    .EDGE_PIN(pins), .SOURCE_ON(son), .DELAY_DONE(done), .ADC_SOC(soc), .SOURCE_GROUND(gnd));
  ctec_far_model far (.CLK(CLK), .ADC_SOC(soc), .SOURCE_GROUND(gnd), .TIMER_EDGE1(t1),
    .TIMER_EDGE2(t2), .EDGE_PIN(pins), .SAMPLING(smp));
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h, expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 chk(RDATA, e);
  endtask
  // Edges from the status write until the end-of-measurement pulse
  task automatic meas(input logic [15:0] soc_e);
    // The pulse can rise at the very edge that takes the last write
    n = 0;
    #1;
    while (done !== 1'b1 && n < 40) begin
      @(posedge CLK);
      n++;
      #1;
    end
    chk({15'h0, soc}, soc_e);
  endtask
  task automatic end_sim;
    $display("checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #200000;
    n_mismatch++;
    end_sim();
  end
  initial begin
    repeat (2) @(posedge CLK);
    ARST_N <= 1'b1;
    rd(4'h0, 16'h0000);
    rd(4'h1, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      wr(4'h0, rows[i][0]);
      rd(4'h0, rows[i][1]);
      chk({15'h0, gnd}, rows[i][2]);
    end
    wr(4'h5, 16'hffff);
    rd(4'h5, 16'h0000);
    $display("register tests done");
    wr(4'h0, 16'h8200);
    @(posedge CLK);
    #1 chk({15'h0, smp}, 16'h1);
    @(posedge CLK);
    ARST_N <= 1'b0;
    @(posedge CLK);
    ARST_N <= 1'b1;
    #1 chk({15'h0, gnd}, 16'h0000);
    rd(4'h0, 16'h0000);
    $display("reset test done");
    wr(4'h0, 16'h8500);
    wr(4'h1, 16'h0002);
    rd(4'h1, 16'h0000);
    wr(4'h1, 16'h0001);
    @(posedge CLK);
    #1 chk({15'h0, son}, 16'h1);
    wr(4'h1, 16'h0003);
    meas(16'h1);
    chk(16'(n), 16'h0000);
    wr(4'h1, 16'h0000);
    wr(4'h0, 16'h9000);
    wr(4'h1, 16'h0001);
    wr(4'h1, 16'h0003);
    meas(16'h0);
    chk(16'(n), 16'(DLY));
    chk(16'(far.soc_seen), 16'h1);
    wr(4'h1, 16'h0000);
    far.tmr(1);
    rd(4'h1, 16'h0000);
    wr(4'h0, 16'ha800);
    CPU_IDLE <= 1'b1;
    far.tmr(1);
    rd(4'h1, 16'h0000);
    CPU_IDLE <= 1'b0;
    wr(4'h1, 16'h0001);
    rd(4'h1, 16'h0000);
    far.tmr(1);
    repeat (3) @(posedge CLK);
    #1 chk({15'h0, son}, 16'h1);
    far.pin(2'h2);
    meas(16'h0);
    chk({15'h0, n < 40}, 16'h1);
    far.pin(2'h0);
    wr(4'h1, 16'h0000);
    wr(4'h0, 16'h8c00);
    far.tmr(2);
    rd(4'h1, 16'h0000);
    far.pin(2'h1);
    repeat (6) @(posedge CLK);
    #1 chk({15'h0, son}, 16'h1);
    far.tmr(2);
    meas(16'h0000);
    chk(16'(n), 16'h0000);
    far.pin(2'h0);
    $display("measurement tests done");
    end_sim();
  end
endmodule // tb_ctec_top
